// [hdl/pdl_edge_detect.sv]
// rising and falling edge detection of one level
module pdl_edge_detect
    import pdl_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // level to watch
    input wire logic level,
    // edge pulses
    pdl_edge_if.src edge_out
);
    logic prev_reg;
    logic prev_next;

    // remember the level of the previous cycle
    always_comb begin
        prev_next = level;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            // follow the level during reset so release shows no false edge
            prev_reg <= prev_next;
        end else begin
            prev_reg <= prev_next;
        end
    end

    // one-cycle pulses in the cycle the level changes
    assign edge_out.rise = level & ~prev_reg;
    assign edge_out.fall = ~level & prev_reg;
endmodule : pdl_edge_detect

// [hdl/pdl_position_latch.sv]
// two-channel probe position latch for the drive
//
// Operation
// [RULE1] Two latch channels work side by side and neither disturbs the other.
// [RULE2] On a qualifying trigger the actual position is captured at once.
// [RULE3] Channel one takes its settings from the low byte of the control object.
// [RULE4] Channel two takes its settings from the high byte of the control object.
// [RULE5] Channel one reports its latch state in the low byte of the status object.
// [RULE6] Channel two reports its latch state in the high byte of the status object.
// [RULE7] Channel one captures go only into the channel-one position object.
// [RULE8] Channel two captures go only into the channel-two position object.
// [RULE9] Channel one triggers on either the zero marker or its own probe input.
// [RULE10] Channel two triggers only on its own probe input, never on the marker.
// [RULE11] Channel one is off while homing runs and is switched off when it starts.
// [RULE12] Once bit 4 or 12 is set, writes to bit 2 or 10 of that channel are ignored.
// [RULE13] With bit 1 or 9 clear a channel captures only the first event after arming.
// [RULE14] Pin choice and polarity of each probe input come from a setup parameter.
// [RULE15] With bit 1 or 9 set a channel overwrites its capture on every event.
// [RULE16] Control and status come out of reset at zero, both channels disabled.
module pdl_position_latch
    import pdl_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control object written by the motion controller
    input wire logic probe_control_wr,
    input wire logic [CTL_W-1:0] probe_control_wdata,
    // objects read by the motion controller
    output logic [CTL_W-1:0] probe_control,
    output logic [CTL_W-1:0] probe_status,
    output logic [POS_W-1:0] probe1_latched_position,
    output logic [POS_W-1:0] probe2_latched_position,
    // drive side
    input wire logic [POS_W-1:0] actual_position,
    input wire logic homing_active,
    input wire logic encoder_zero_pulse,
    // probe pins and their setup
    input wire logic [PIN_COUNT-1:0] probe_input_pins,
    input wire logic [SETUP_W-1:0] probe_input_setup_param
);
    // control register state
    logic [CTL_W-1:0] control_reg;
    logic [CTL_W-1:0] control_next;
    logic homing_prev_reg;
    logic homing_prev_next;

    // conditioned trigger levels
    logic probe1_trigger_input;
    logic probe2_trigger_input;
    logic [SRC_COUNT-1:0] src_level;

    // per-channel results gathered for the outputs
    pdl_byte_t status_byte [CH_COUNT];
    pdl_pos_t pos_word [CH_COUNT];

    // ------------------------------------------------------------
    // probe input conditioning
    // ------------------------------------------------------------

    // channel one probe input, pin and polarity from the setup field
    pdl_probe_select u_sel1 (
        .pins(probe_input_pins),
        .setup(probe_input_setup_param[0 +: SETUP_FIELD_W]), // [RULE14]
        .active(probe1_trigger_input)
    );

    // channel two probe input, pin and polarity from the setup field
    pdl_probe_select u_sel2 (
        .pins(probe_input_pins),
        .setup(probe_input_setup_param[SETUP_FIELD_W +: SETUP_FIELD_W]), // [RULE14]
        .active(probe2_trigger_input)
    );

    // source order: probe one, probe two, zero marker
    assign src_level = {encoder_zero_pulse, probe2_trigger_input, probe1_trigger_input};

    // edge events for every source
    pdl_edge_if src_edge [SRC_COUNT] ();

    genvar s;
    generate
        for (s = 0; s < SRC_COUNT; s++) begin : g_src
            pdl_edge_detect u_edge (
                .clock(clock),
                .rst(rst),
                .level(src_level[s]),
                .edge_out(src_edge[s])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // control object
    // ------------------------------------------------------------

    // take controller writes, freeze the source bit, drop channel one at homing start
    always_comb begin
        control_next = control_reg;
        homing_prev_next = homing_active;
        if (probe_control_wr) begin
            control_next = probe_control_wdata; // [RULE3] [RULE4]
            for (int c = 0; c < CH_COUNT; c++) begin
                if (control_reg[c*CH_BYTE_W + PC_RISE_EN_BIT]) begin
                    // source bit keeps its old value once rising-edge sampling is on
                    control_next[c*CH_BYTE_W + PC_ZERO_SEL_BIT] =
                        control_reg[c*CH_BYTE_W + PC_ZERO_SEL_BIT]; // [RULE12]
                end
            end
        end
        if (homing_active && !homing_prev_reg) begin
            control_next[PC_ENABLE_BIT] = 1'b0; // [RULE11]
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            control_reg <= PROBE_CONTROL_RESET; // [RULE16]
            homing_prev_reg <= 1'b0;
        end else begin
            control_reg <= control_next;
            homing_prev_reg <= homing_prev_next;
        end
    end

    assign probe_control = control_reg;

    // ------------------------------------------------------------
    // latch channels, one block of state each
    // ------------------------------------------------------------

    genvar c;
    generate
        for (c = 0; c < CH_COUNT; c++) begin : g_ch // [RULE1]
            pdl_byte_t ctl;
            logic enabled;
            logic use_zero;
            logic hit_rise;
            logic hit_fall;
            logic capture;

            logic en_prev_reg;
            logic en_prev_next;
            logic armed_reg;
            logic armed_next;
            logic rise_reg;
            logic rise_next;
            logic fall_reg;
            logic fall_next;
            logic toggle_reg;
            logic toggle_next;
            pdl_pos_t pos_reg;
            pdl_pos_t pos_next;

            // this channel's own control byte
            assign ctl = control_reg[c*CH_BYTE_W +: CH_BYTE_W]; // [RULE3] [RULE4]

            // channel one is held off for the whole homing run
            if (c == 0) begin : g_home
                assign enabled = ctl[PC_ENABLE_BIT] & ~homing_active; // [RULE11]
                assign use_zero = ctl[PC_ZERO_SEL_BIT]; // [RULE9]
            end else begin : g_nohome
                assign enabled = ctl[PC_ENABLE_BIT];
                assign use_zero = 1'b0; // [RULE10]
            end

            // qualifying edges from the chosen source
            assign hit_rise = ctl[PC_RISE_EN_BIT] &
                (use_zero ? src_edge[SRC_ZERO].rise : src_edge[c].rise); // [RULE9]
            assign hit_fall = ctl[PC_FALL_EN_BIT] & ~use_zero & src_edge[c].fall;
            assign capture = armed_reg & enabled & (hit_rise | hit_fall); // [RULE2]

            // arming, capture flags and position
            always_comb begin
                en_prev_next = enabled;
                armed_next = armed_reg;
                rise_next = rise_reg;
                fall_next = fall_reg;
                toggle_next = toggle_reg;
                pos_next = pos_reg;
                if (!enabled) begin
                    // disabled: nothing armed, nothing reported
                    armed_next = 1'b0;
                    rise_next = 1'b0;
                    fall_next = 1'b0;
                    toggle_next = 1'b0;
                end else if (!en_prev_reg) begin
                    // fresh enable arms the channel
                    armed_next = 1'b1;
                    rise_next = 1'b0;
                    fall_next = 1'b0;
                end else if (capture) begin
                    pos_next = actual_position; // [RULE2] [RULE7] [RULE8]
                    if (hit_rise) begin
                        rise_next = 1'b1;
                    end
                    if (hit_fall) begin
                        fall_next = 1'b1;
                    end
                    if (ctl[PC_CONT_BIT]) begin
                        toggle_next = ~toggle_reg; // [RULE15]
                    end else begin
                        armed_next = 1'b0; // [RULE13]
                    end
                end
            end

            always_ff @(posedge clock) begin
                if (rst) begin
                    en_prev_reg <= 1'b0; // [RULE16]
                    armed_reg <= 1'b0;
                    rise_reg <= 1'b0;
                    fall_reg <= 1'b0;
                    toggle_reg <= 1'b0;
                    pos_reg <= POSITION_RESET;
                end else begin
                    en_prev_reg <= en_prev_next;
                    armed_reg <= armed_next;
                    rise_reg <= rise_next;
                    fall_reg <= fall_next;
                    toggle_reg <= toggle_next;
                    pos_reg <= pos_next;
                end
            end

            // status byte assembled from flops only
            always_comb begin
                status_byte[c] = STATUS_BYTE_RESET;
                status_byte[c][PS_ENABLED_BIT] = en_prev_reg;
                status_byte[c][PS_RISE_BIT] = rise_reg;
                status_byte[c][PS_FALL_BIT] = fall_reg;
                status_byte[c][PS_TOGGLE_BIT] = toggle_reg;
            end

            assign pos_word[c] = pos_reg;
        end
    endgenerate

    // ------------------------------------------------------------
    // objects toward the controller
    // ------------------------------------------------------------

    // channel bytes into the status object
    assign probe_status = {status_byte[1], status_byte[0]}; // [RULE5] [RULE6]

    // each channel owns exactly one position object
    assign probe1_latched_position = pos_word[0]; // [RULE7]
    assign probe2_latched_position = pos_word[1]; // [RULE8]
endmodule : pdl_position_latch

// [hdl/pdl_probe_select.sv]
// pin selection and polarity for one probe input
module pdl_probe_select
    import pdl_pkg::*;
(
    // probe pin bank
    input wire logic [PIN_COUNT-1:0] pins,
    // setup field: pin index and polarity
    input wire logic [SETUP_FIELD_W-1:0] setup,
    // conditioned level, high when the probe is active
    output logic active
);
    logic [PIN_SEL_W-1:0] pin_idx;

    // pick the pin, then invert unless the field asks active high
    assign pin_idx = setup[PIN_SEL_W-1:0];
    assign active = setup[SETUP_POL_BIT] ? pins[pin_idx] : ~pins[pin_idx];
endmodule : pdl_probe_select

// [shared/pdl_edge_if.sv]
// edge events of one conditioned trigger source
interface pdl_edge_if;
    logic rise;
    logic fall;

    // producer side: the edge detector
    modport src (
        output rise,
        output fall
    );

    // consumer side: the latch channels
    modport snk (
        input rise,
        input fall
    );
endinterface : pdl_edge_if

// [shared/pdl_pkg.sv]
// constants and types for the two-channel position latch
package pdl_pkg;
    // object indices of the cyclic fieldbus objects
    localparam logic [15:0] OBJ_PROBE_CONTROL = 16'h60b8;
    localparam logic [15:0] OBJ_PROBE_STATUS = 16'h60b9;
    localparam logic [15:0] OBJ_PROBE1_POSITION = 16'h60ba;
    localparam logic [15:0] OBJ_PROBE2_POSITION = 16'h60bc;

    // channel layout
    localparam int CH_COUNT = 2;
    localparam int CH_BYTE_W = 8;
    localparam int SRC_COUNT = 3;
    localparam int SRC_ZERO = 2;
    localparam int POS_W = 32;
    localparam int CTL_W = 16;

    // control byte fields, per channel
    localparam int PC_ENABLE_BIT = 0;
    localparam int PC_CONT_BIT = 1;
    localparam int PC_ZERO_SEL_BIT = 2;
    localparam int PC_RISE_EN_BIT = 4;
    localparam int PC_FALL_EN_BIT = 5;

    // status byte fields, per channel
    localparam int PS_ENABLED_BIT = 0;
    localparam int PS_RISE_BIT = 1;
    localparam int PS_FALL_BIT = 2;
    localparam int PS_TOGGLE_BIT = 6;

    // input setup field, per channel: pin index and polarity
    localparam int PIN_COUNT = 4;
    localparam int PIN_SEL_W = 2;
    localparam int SETUP_FIELD_W = 4;
    localparam int SETUP_POL_BIT = 2;
    localparam int SETUP_W = 8;

    // values after reset
    localparam logic [15:0] PROBE_CONTROL_RESET = 16'h0000;
    localparam logic [7:0] STATUS_BYTE_RESET = 8'h00;
    localparam logic [31:0] POSITION_RESET = 32'h0000_0000;

    typedef logic [CH_BYTE_W-1:0] pdl_byte_t;
    typedef logic signed [POS_W-1:0] pdl_pos_t;
endpackage : pdl_pkg

// [test/pdl_ctl_model.sv]
// motion controller model that writes the probe control object
module pdl_ctl_model
    import pdl_pkg::*;
(
    // clock
    input wire logic clock,
    // control object write side
    output logic probe_control_wr,
    output logic [CTL_W-1:0] probe_control_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle with the strobe low
    initial begin
        probe_control_wr = 1'b0;
        probe_control_wdata = 16'h0000;
    end

    // one write: low byte sets channel one, high byte channel two
    task automatic write_ctl(input logic [CTL_W-1:0] value);
        @(posedge clock);
        probe_control_wr <= 1'b1;
        probe_control_wdata <= value;
        @(posedge clock);
        probe_control_wr <= 1'b0;
        probe_control_wdata <= ~value; // stale data not left on the bus
    endtask : write_ctl
endmodule : pdl_ctl_model

// [test/pdl_position_latch_assertions.sv]
// port checks of the two-channel position latch
module pdl_position_latch_assertions
    import pdl_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control and readback objects
    input wire logic probe_control_wr,
    input wire logic [CTL_W-1:0] probe_control_wdata,
    input wire logic [CTL_W-1:0] probe_control,
    input wire logic [CTL_W-1:0] probe_status,
    input wire logic [POS_W-1:0] probe1_latched_position,
    input wire logic [POS_W-1:0] probe2_latched_position,
    // drive side and probe pins
    input wire logic [POS_W-1:0] actual_position,
    input wire logic homing_active,
    input wire logic encoder_zero_pulse,
    input wire logic [PIN_COUNT-1:0] probe_input_pins,
    input wire logic [SETUP_W-1:0] probe_input_setup_param
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic lvl2;

    // conditioned level of probe two
    assign lvl2 = probe_input_pins[probe_input_setup_param[5:4]] ~^ probe_input_setup_param[6];

    // a qualifying probe two edge while armed
    sequence s_edge2;
        probe_status[8] && probe_control[8] && probe_control[12] && !probe_control_wr
        && (probe_control[9] || !(probe_status[9] || probe_status[10]))
        && lvl2 && !$past(lvl2);
    endsequence
    // a zero marker rise on continuous channel one
    sequence s_zero1;
        probe_status[0] && probe_control[0] && probe_control[1] && probe_control[2]
        && probe_control[4] && !homing_active && !probe_control_wr
        && $rose(encoder_zero_pulse);
    endsequence

    property p_reset;
        $fell(rst) |-> probe_control == 16'h0000 && probe_status == 16'h0000
            && probe1_latched_position == 32'h0 && probe2_latched_position == 32'h0;
    endproperty
    property p_ctl_low;
        probe_control_wr |=> probe_control[7:3] == $past(probe_control_wdata[7:3])
            && probe_control[1] == $past(probe_control_wdata[1]);
    endproperty
    property p_ctl_high;
        probe_control_wr |=> {probe_control[15:11], probe_control[9:8]}
            == $past({probe_control_wdata[15:11], probe_control_wdata[9:8]});
    endproperty
    property p_lock;
        probe_control_wr && probe_control[12] |=> probe_control[10] == $past(probe_control[10]);
    endproperty
    property p_home;
        $rose(homing_active) |=> !probe_control[0];
    endproperty
    property p_home_hold;
        homing_active && $past(homing_active) && $past(homing_active, 2)
            |-> $stable(probe1_latched_position);
    endproperty
    property p_cap2;
        s_edge2 |=> probe2_latched_position == $past(actual_position) && probe_status[9];
    endproperty
    property p_single2;
        probe_status[8] && probe_control[8] && !probe_control[9] && |probe_status[10:9]
            |=> $stable(probe2_latched_position);
    endproperty
    property p_quiet2;
        lvl2 == $past(lvl2) |=> $stable(probe2_latched_position);
    endproperty
    property p_cap1;
        s_zero1 |=> probe1_latched_position == $past(actual_position)
            && probe_status[6] != $past(probe_status[6]);
    endproperty
    property p_reserved;
        (probe_status & 16'hb8b8) == 16'h0000;
    endproperty

    a_reset: assert property (p_reset) else $error("values after reset not zero");
    a_ctl_low: assert property (p_ctl_low) else $error("low control byte not stored");
    a_ctl_high: assert property (p_ctl_high) else $error("high control byte not stored");
    a_lock: assert property (p_lock) else $error("locked source bit changed");
    a_home: assert property (p_home) else $error("channel one left on at homing");
    a_home_hold: assert property (p_home_hold) else $error("capture during homing");
    a_cap2: assert property (p_cap2) else $error("channel two capture wrong");
    a_single2: assert property (p_single2) else $error("second single capture");
    a_quiet2: assert property (p_quiet2) else $error("channel two moved unprompted");
    a_cap1: assert property (p_cap1) else $error("marker capture wrong");
    a_reserved: assert property (p_reserved) else $error("unused status bit set");
endmodule : pdl_position_latch_assertions

// [test/tb_top.sv]
// testbench of the two-channel position latch
module tb_top
    import pdl_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, rst, wr, homing, zero, pol1, pol2;
    logic [15:0] wdata, pc, ps;
    logic [31:0] p1, p2, apos, v, w;
    logic [3:0] pins;
    logic [7:0] setup;
    logic [1:0] a1, a2;
    int num_errors, tests_run;

    pdl_position_latch uut (.clock(clock), .rst(rst), .probe_control_wr(wr),
        .probe_control_wdata(wdata), .probe_control(pc), .probe_status(ps),
        .probe1_latched_position(p1), .probe2_latched_position(p2),
        .actual_position(apos), .homing_active(homing), .encoder_zero_pulse(zero),
        .probe_input_pins(pins), .probe_input_setup_param(setup));
    pdl_ctl_model ctl (.clock(clock), .probe_control_wr(wr), .probe_control_wdata(wdata));

    // clock generator
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // pin bank for two probe levels, unselected pins random
    function automatic logic [3:0] pin_word(input logic l1, input logic l2);
        logic [3:0] p;
        p = 4'($urandom);
        p[a1] = l1 ~^ pol1;
        p[a2] = l2 ~^ pol2;
        return p;
    endfunction : pin_word

    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // new levels in one cycle, sampled after the capturing edge
    task automatic step(input logic l1, input logic l2, input logic z, input logic [31:0] pos);
        @(posedge clock);
        pins <= pin_word(l1, l2);
        zero <= z;
        apos <= pos;
        @(posedge clock);
        #1;
    endtask : step

    // report and end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // hang guard
    initial begin
        repeat (3000) @(posedge clock);
        num_errors++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        num_errors = 0;
        tests_run = 0;
        void'($urandom(32'h5a5e));
        a1 = 2'($urandom);
        a2 = a1 + 2'h1;
        {pol1, pol2} = 2'($urandom);
        setup = {1'b0, pol2, a2, 1'b0, pol1, a1};
        rst = 1'b1;
        homing = 1'b0;
        zero = 1'b0;
        apos = 32'h0;
        pins = pin_word(1'b0, 1'b0);
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        check("control", 32'(pc), 32'h0);
        check("status", 32'(ps), 32'h0);
        step(1'b1, 1'b0, 1'b0, 32'h0);
        // ch1 probe falling edge, ch2 probe rising edge, both single
        ctl.write_ctl(16'h1121);
        v = $urandom;
        step(1'b0, 1'b1, 1'b0, v);
        check("pos1", p1, v);
        check("pos2", p2, v);
        check("status", 32'(ps), 32'h0305);
        w = ~v;
        step(1'b1, 1'b0, 1'b0, w);
        step(1'b0, 1'b1, 1'b0, w);
        check("pos1", p1, v);
        check("pos2", p2, v);
        // continuous, ch1 on marker; then try to flip locked source bits
        ctl.write_ctl(16'h0000);
        ctl.write_ctl(16'h1317);
        ctl.write_ctl(16'h1713);
        @(posedge clock);
        #1;
        check("control", 32'(pc), 32'h1317);
        for (int i = 0; i < 4; i++) begin
            w = $urandom;
            step(1'b0, 1'b0, 1'b1, w);
            check("pos1", p1, w);
            check("pos2", p2, v);
            v = $urandom;
            step(1'b0, 1'b1, 1'b0, v);
            check("pos2", p2, v);
            check("pos1", p1, w);
        end
        // homing turns channel one off
        @(posedge clock);
        homing <= 1'b1;
        step(1'b0, 1'b0, 1'b1, ~v);
        check("control", 32'(pc), 32'h1316);
        check("ch1 status", 32'(ps[7:0]), 32'h0);
        check("pos1", p1, w);
        check("pos2", p2, v);
        // re-enable during homing must not bring channel one back
        ctl.write_ctl(16'h1317);
        step(1'b0, 1'b0, 1'b0, v);
        step(1'b0, 1'b0, 1'b1, ~w);
        check("ch1 status", 32'(ps[7:0]), 32'h0);
        check("pos1", p1, w);
        check("pos2", p2, v);
        // second reset in mid-run clears every object
        @(posedge clock);
        homing <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        check("control", 32'(pc), 32'h0);
        check("status", 32'(ps), 32'h0);
        check("pos1", p1, 32'h0);
        check("pos2", p2, 32'h0);
        tally_and_finish();
    end
endmodule : tb_top

bind pdl_position_latch pdl_position_latch_assertions u_chk (.clock, .rst, .probe_control_wr,
    .probe_control_wdata, .probe_control, .probe_status, .probe1_latched_position,
    .probe2_latched_position, .actual_position, .homing_active, .encoder_zero_pulse,
    .probe_input_pins, .probe_input_setup_param);
